// file: include/boot_cfg_defines.svh
// Constants of the boot strap configuration sequencer.
// Definitions only; included by the package, the sequencer and the test bench.
`ifndef BOOT_CFG_DEFINES_SVH
`define BOOT_CFG_DEFINES_SVH

// First-fetch targets
`define ROM_START_VEC 32'h0000_8000
`define EMIF_START_VEC 32'h0200_0000

// Module numbers in the enable vector
`define MOD_COUNT 41
`define MOD_DMA_CC 2
`define MOD_DMA_TC0 3
`define MOD_DMA_TC1 4
`define MOD_EMIF 14
`define MOD_CARD0 15
`define MOD_UART0 19
`define MOD_FIRST_GENERAL_TIMER 27
`define MOD_TIMER2 29
`define MOD_SYSTEM 30
`define MOD_CPU 31
`define MOD_BUS_LO 32
`define MOD_BUS_HI 38

// Slowest external memory wait states, in interface cycles
`define WAIT_SETUP 5'h10
`define WAIT_STROBE 7'h40
`define WAIT_HOLD 4'h8
`define WAIT_TOTAL 8'h58

// Loader limits
`define RETRY_LIMIT 5'h18
`define MAX_LOAD_BYTES 16'h7800
`define MAX_PAGE_BYTES 16'h2000

// Timing: clock rate and status toggle rates
`define MCLK_HZ 32'h05F5_E100
`define BLINK_FAST_HZ 32'h4
`define BLINK_SLOW_HZ 32'h2

`endif

// file: include/boot_cfg_pkg.sv
// Types shared by the boot strap configuration sequencer and its helpers.
// Assumes boot_cfg_defines.svh is on the include path.
`include "boot_cfg_defines.svh"

package boot_cfg_pkg;

  // Boot-select strap coding
  typedef enum logic [1:0] {
    SEL_NAND = 2'h0,
    SEL_EMIF = 2'h1,
    SEL_CARD = 2'h2,
    SEL_UART = 2'h3
  } boot_sel_e;

  typedef enum logic [1:0] {
    SRC_NAND = 2'h0,
    SRC_CARD = 2'h1,
    SRC_USB = 2'h2,
    SRC_UART = 2'h3
  } load_src_e;

  typedef enum logic [1:0] {
    STAT_LOW = 2'h0,
    STAT_FAST = 2'h1,
    STAT_SLOW = 2'h2,
    STAT_HIGH = 2'h3
  } status_mode_e;

  // Gray codes along the ROM path
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_INIT = 3'h1,
    ST_READ_CFG = 3'h3,
    ST_LOAD = 3'h2,
    ST_WAIT = 3'h6,
    ST_HANDOFF = 3'h7,
    ST_RUN = 3'h5
  } seq_state_e;

  typedef logic [`MOD_COUNT-1:0] mod_en_t;

  typedef struct packed {
    logic [4:0] setup;
    logic [6:0] strobe;
    logic [3:0] hold;
  } emif_wait_s;

  typedef struct packed {
    load_src_e src;
    logic cs_hold;
    logic card_native;
  } load_req_s;

  typedef struct packed {
    logic ok;
    logic chk_err;
    logic [15:0] bytes;
  } load_rsp_s;

endpackage

// file: design/strap_sampler.sv
// Strap pin synchroniser and reset-time latch.
// Pins are asynchronous; value is taken once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module strap_sampler
  import boot_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_strap_pin,
  output logic [1:0] o_strap,
  output logic o_latched
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] fill;
    logic [1:0] strap;
    logic latched;
  } smp_state_s;

  smp_state_s smp_r;
  smp_state_s smp_nxt;

  // Stage one feeds only stage two; capture waits for a full pipe
  always_comb begin
    smp_nxt = smp_r;
    smp_nxt.s1 = i_strap_pin;
    smp_nxt.s2 = smp_r.s1;
    smp_nxt.s3 = smp_r.s2;
    if (smp_r.fill != 2'h3) begin
      smp_nxt.fill = smp_r.fill + 2'h1;
    end
    if (!smp_r.latched && smp_r.fill == 2'h3 && smp_r.s2 == smp_r.s3) begin
      smp_nxt.strap = smp_r.s3;
      smp_nxt.latched = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp_r <= '0;
    end else begin
      smp_r <= smp_nxt;
    end
  end

  assign o_strap = smp_r.strap;
  assign o_latched = smp_r.latched;

endmodule

`default_nettype wire

// file: design/status_blinker.sv
// Boot status pin driver timed by the first general timer.
// Steady low or high, or toggling at the fast or slow rate.
`timescale 1ns/100ps
`default_nettype none

module status_blinker
  import boot_cfg_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = 25000000,
  parameter int unsigned SLOW_CYCLES = 50000000
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_timer_run,
  input wire status_mode_e i_mode,
  output logic o_level
);

  typedef struct packed {
    logic [25:0] cnt;
    logic tick;
    logic level;
  } blk_state_s;

  blk_state_s blk_r;
  blk_state_s blk_nxt;
  logic [25:0] limit;

  // Divider makes a one-cycle tick; the level flips on the tick
  always_comb begin
    blk_nxt = blk_r;
    blk_nxt.tick = 1'b0;
    limit = (i_mode == STAT_SLOW) ? 26'(SLOW_CYCLES - 1) :
                                    26'(FAST_CYCLES - 1);
    unique case (i_mode)
      STAT_LOW: begin
        blk_nxt.level = 1'b0;
        blk_nxt.cnt = '0;
      end
      STAT_HIGH: begin
        blk_nxt.level = 1'b1;
        blk_nxt.cnt = '0;
      end
      STAT_FAST, STAT_SLOW: begin
        if (i_timer_run) begin
          if (blk_r.cnt >= limit) begin
            blk_nxt.cnt = '0;
            blk_nxt.tick = 1'b1;
          end else begin
            blk_nxt.cnt = blk_r.cnt + 26'h1;
          end
        end
        if (blk_r.tick) begin
          blk_nxt.level = ~blk_r.level;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_r <= '0;
    end else begin
      blk_r <= blk_nxt;
    end
  end

  assign o_level = blk_r.level;

endmodule

`default_nettype wire

// file: design/boot_strap_config_sequencer.sv
// Reset-time boot configuration and ROM loader sequencer.
// Assumes a load engine that answers each start with one done pulse,
// and a single reset that stands for power-on, warm and max reset.
`timescale 1ns/100ps
`include "boot_cfg_defines.svh"
`default_nettype none

module boot_strap_config_sequencer
  import boot_cfg_pkg::*;
#(
  parameter int unsigned TOGGLE_FAST_CYCLES = `MCLK_HZ / `BLINK_FAST_HZ,
  parameter int unsigned TOGGLE_SLOW_CYCLES = `MCLK_HZ / `BLINK_SLOW_HZ
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_boot_select_strap,
  input wire logic i_load_done,
  input wire load_rsp_s i_load_rsp,
  input wire logic [15:0] i_nand_page_bytes,
  input wire logic i_nand_wide,
  output logic o_pins_to_emif,
  output logic [1:0] o_boot_config_word,
  output logic [31:0] o_fetch_vector,
  output logic o_fetch_go,
  output mod_en_t o_module_enable,
  output emif_wait_s o_emif_wait,
  output logic o_load_start,
  output load_req_s o_load_req,
  output logic o_boot_status_output,
  output logic o_handoff
);

  typedef struct packed {
    seq_state_e st;
    logic [1:0] cfg_word;
    logic pins_emif;
    logic [31:0] vector;
    logic go;
    mod_en_t mod_en;
    emif_wait_s wait_cfg;
    logic start;
    load_req_s req;
    logic [4:0] retries;
    logic fallback;
    status_mode_e stat;
    logic handoff;
  } seq_state_s;

  seq_state_s seq_r;
  seq_state_s seq_nxt;
  logic [1:0] strap;
  logic strap_latched;
  logic status_level;
  logic load_good;
  logic retry_ok;
  logic nand_unsupported;

  // Per-module run/held pattern for one strap value
  function automatic mod_en_t module_defaults(input logic [1:0] sel);
    mod_en_t en;
    en = '0;
    en[`MOD_DMA_CC] = (sel != SEL_CARD);
    en[`MOD_DMA_TC0] = (sel != SEL_CARD);
    en[`MOD_DMA_TC1] = (sel != SEL_CARD);
    en[`MOD_EMIF] = (sel != SEL_CARD);
    en[`MOD_CARD0] = (sel == SEL_CARD);
    en[`MOD_UART0] = (sel == SEL_UART);
    en[`MOD_FIRST_GENERAL_TIMER] = 1'b1;
    en[`MOD_TIMER2] = 1'b1;
    en[`MOD_SYSTEM] = 1'b1;
    en[`MOD_CPU] = 1'b1;
    for (int i = `MOD_BUS_LO; i <= `MOD_BUS_HI; i++) begin
      en[i] = 1'b1;
    end
    return en;
  endfunction

  // Next source after a failed attempt
  function automatic load_src_e fallback_src(input load_src_e src);
    unique case (src)
      SRC_NAND: fallback_src = SRC_CARD;
      SRC_CARD: fallback_src = SRC_USB;
      SRC_USB: fallback_src = SRC_USB;
      SRC_UART: fallback_src = SRC_UART;
    endcase
  endfunction

  // Strap capture; the pins are released only after it
  strap_sampler u_strap (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_strap_pin(i_boot_select_strap),
    .o_strap(strap),
    .o_latched(strap_latched)
  );

  // Status pin paced by the first general timer
  status_blinker #(
    .FAST_CYCLES(TOGGLE_FAST_CYCLES),
    .SLOW_CYCLES(TOGGLE_SLOW_CYCLES)
  ) u_blink (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_timer_run(seq_r.mod_en[`MOD_FIRST_GENERAL_TIMER]),
    .i_mode(seq_r.stat),
    .o_level(status_level)
  );

  // Answer classification of the running attempt
  assign load_good = i_load_rsp.ok &&
                     (i_load_rsp.bytes <= `MAX_LOAD_BYTES);
  assign retry_ok = i_load_rsp.chk_err &&
                    (seq_r.req.src == SRC_NAND ||
                     seq_r.req.src == SRC_CARD) &&
                    (seq_r.retries < `RETRY_LIMIT);
  assign nand_unsupported = i_nand_wide ||
                            (i_nand_page_bytes > `MAX_PAGE_BYTES);

  // Boot sequence; a single reset covers every reset kind
  always_comb begin
    seq_nxt = seq_r;
    seq_nxt.go = 1'b0;
    seq_nxt.start = 1'b0;
    seq_nxt.handoff = 1'b0;
    unique case (seq_r.st)
      ST_SAMPLE: begin
        if (strap_latched) begin
          seq_nxt.cfg_word = strap;
          seq_nxt.pins_emif = 1'b1;
          seq_nxt.mod_en = module_defaults(strap);
          if (strap != SEL_CARD) begin
            seq_nxt.wait_cfg = '{`WAIT_SETUP, `WAIT_STROBE,
                                 `WAIT_HOLD};
          end
          seq_nxt.go = 1'b1;
          if (strap == SEL_EMIF) begin
            seq_nxt.vector = `EMIF_START_VEC;
            seq_nxt.st = ST_RUN;
          end else begin
            seq_nxt.vector = `ROM_START_VEC;
            seq_nxt.st = ST_INIT;
          end
        end
      end
      ST_INIT: begin
        seq_nxt.st = ST_READ_CFG;
      end
      ST_READ_CFG: begin
        // Branch on the latched configuration word
        unique case (seq_r.cfg_word)
          SEL_CARD: seq_nxt.req.src = SRC_CARD;
          SEL_UART: seq_nxt.req.src = SRC_UART;
          default: seq_nxt.req.src = SRC_NAND;
        endcase
        seq_nxt.retries = '0;
        seq_nxt.st = ST_LOAD;
      end
      ST_LOAD: begin
        if (seq_r.req.src == SRC_NAND && nand_unsupported) begin
          // Unsupported part counts as a failed NAND attempt
          seq_nxt.req.src = SRC_CARD;
          seq_nxt.fallback = 1'b1;
        end else begin
          seq_nxt.start = 1'b1;
          seq_nxt.req.cs_hold = (seq_r.req.src == SRC_NAND);
          seq_nxt.req.card_native = (seq_r.req.src == SRC_CARD);
          seq_nxt.st = ST_WAIT;
          if (!seq_r.fallback) begin
            seq_nxt.stat = STAT_LOW;
          end else if (seq_r.req.src == SRC_UART) begin
            seq_nxt.stat = STAT_SLOW;
          end else begin
            seq_nxt.stat = STAT_FAST;
          end
        end
      end
      ST_WAIT: begin
        if (i_load_done) begin
          if (load_good) begin
            seq_nxt.stat = STAT_HIGH;
            seq_nxt.st = ST_HANDOFF;
          end else if (retry_ok) begin
            seq_nxt.retries = seq_r.retries + 5'h1;
            seq_nxt.st = ST_LOAD;
          end else begin
            seq_nxt.req.src = fallback_src(seq_r.req.src);
            seq_nxt.fallback = 1'b1;
            seq_nxt.retries = '0;
            seq_nxt.st = ST_LOAD;
          end
        end
      end
      ST_HANDOFF: begin
        // Jump only once the pin already shows high
        if (status_level) begin
          seq_nxt.handoff = 1'b1;
          seq_nxt.req.cs_hold = 1'b0;
          seq_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        seq_nxt.st = ST_RUN;
      end
      default: begin
        seq_nxt.st = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_r <= '0;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // Outputs straight from the state register; status pin from the blinker register
  assign o_pins_to_emif = seq_r.pins_emif;
  assign o_boot_config_word = seq_r.cfg_word;
  assign o_fetch_vector = seq_r.vector;
  assign o_fetch_go = seq_r.go;
  assign o_module_enable = seq_r.mod_en;
  assign o_emif_wait = seq_r.wait_cfg;
  assign o_load_start = seq_r.start;
  assign o_load_req = seq_r.req;
  assign o_boot_status_output = status_level;
  assign o_handoff = seq_r.handoff;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic fail_now;
  assign fail_now = (seq_r.st == ST_WAIT) && i_load_done &&
                    !load_good && !retry_ok;

  chk_emif_vector: assert property (
    o_fetch_go && o_boot_config_word == SEL_EMIF |->
      o_fetch_vector == `EMIF_START_VEC ##1 !o_load_start [*3])
    else $error("external boot vector wrong or loader started");
  chk_rom_vector: assert property (
    o_fetch_go && o_boot_config_word != SEL_EMIF |->
      o_fetch_vector == `ROM_START_VEC ##1 seq_r.st == ST_READ_CFG)
    else $error("ROM boot vector or loader entry wrong");
  chk_wait_slowest: assert property (
    $rose(o_pins_to_emif) && o_module_enable[`MOD_EMIF] |->
      o_emif_wait.setup + o_emif_wait.strobe + o_emif_wait.hold
        == `WAIT_TOTAL)
    else $error("external memory wait states not slowest");
  chk_emif_enable: assert property (
    $rose(o_pins_to_emif) |->
      o_module_enable[`MOD_EMIF] == (o_boot_config_word != SEL_CARD))
    else $error("external memory enable wrong for strap");
  chk_dma_enable: assert property (
    o_pins_to_emif |-> o_module_enable[`MOD_DMA_TC1:`MOD_DMA_CC] ==
      {3{o_boot_config_word != SEL_CARD}})
    else $error("DMA enables wrong for strap");
  chk_card_uart_en: assert property (
    o_pins_to_emif |->
      o_module_enable[`MOD_CARD0] == (o_boot_config_word == SEL_CARD) &&
      o_module_enable[`MOD_UART0] == (o_boot_config_word == SEL_UART))
    else $error("card or UART enable wrong for strap");
  chk_timer_enable: assert property (
    $rose(o_pins_to_emif) |-> o_module_enable[`MOD_FIRST_GENERAL_TIMER] [*4])
    else $error("first general timer not enabled");
  chk_handoff_status: assert property (
    o_handoff |-> o_boot_status_output && $past(o_boot_status_output))
    else $error("handoff without status high beforehand");
  chk_status_low: assert property (
    o_fetch_go |-> !o_boot_status_output)
    else $error("status not low after reset");
  chk_nand_fallback: assert property (
    fail_now && seq_r.req.src == SRC_NAND |->
      ##2 o_load_start && o_load_req.src == SRC_CARD &&
      seq_r.stat == STAT_FAST)
    else $error("NAND failure did not fall back to card");
  chk_usb_retry: assert property (
    fail_now && seq_r.req.src != SRC_NAND &&
      seq_r.req.src != SRC_UART |->
      ##2 o_load_start && o_load_req.src == SRC_USB)
    else $error("card or USB failure did not retry USB");
  chk_uart_retry: assert property (
    fail_now && seq_r.req.src == SRC_UART |->
      ##2 o_load_start && o_load_req.src == SRC_UART &&
      seq_r.stat == STAT_SLOW)
    else $error("UART failure did not retry at slow rate");
  chk_retry_limit: assert property (
    seq_r.retries <= `RETRY_LIMIT)
    else $error("retry count passed its limit");
  chk_nand_cs_hold: assert property (
    o_load_start && o_load_req.src == SRC_NAND |-> o_load_req.cs_hold)
    else $error("NAND chip select hold not requested");

  cov_emif_boot: cover property (
    o_fetch_go && o_boot_config_word == SEL_EMIF);
  cov_handoff: cover property (o_handoff);
  cov_nand_to_card: cover property (
    fail_now && seq_r.req.src == SRC_NAND);
  cov_uart_retry: cover property (
    fail_now && seq_r.req.src == SRC_UART);

endmodule

`default_nettype wire

// file: dv/load_engine_model.sv
// Behavioural load engine standing for boot flash, card or serial host.
// Assumes one start pulse per attempt; answers after a set delay.
`timescale 1ns/100ps
`default_nettype none

module load_engine_model
  import boot_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [7:0] i_fails,
  input wire logic i_err,
  input wire logic [7:0] i_delay,
  input wire logic [15:0] i_bytes,
  output logic o_done,
  output load_rsp_s o_rsp
);
  int tries = 0;

  // Every start is answered; the first i_fails tries fail
  always @(posedge i_mclk) begin
    if (i_rst_n !== 1'b1) begin
      tries = 0;
      o_done = 1'b0;
      o_rsp = '0;
    end else if (i_start === 1'b1) begin
      repeat (i_delay) @(posedge i_mclk);
      #1;
      o_done = 1'b1;
      o_rsp.ok = (tries >= i_fails);
      o_rsp.chk_err = (tries < i_fails) && i_err;
      // Only the first try carries the size under test
      o_rsp.bytes = (tries == 0) ? i_bytes : 16'h0100;
      tries++;
      @(posedge i_mclk);
      #1;
      o_done = 1'b0;
      // Response is stale once done drops, so scramble it
      o_rsp = ~o_rsp;
    end
  end
endmodule
`default_nettype wire

// file: dv/boot_strap_config_sequencer_test.sv
// Self-checking bench for the boot strap configuration sequencer.
// Assumes the load engine model answers every load start.
`timescale 1ns/100ps
`include "boot_cfg_defines.svh"
`default_nettype none

module boot_strap_config_sequencer_test
  import boot_cfg_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, wide = 1'b0, err = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [7:0] fails = 8'h0, dly = 8'h3;
  logic [15:0] page = 16'h0800, bytes = 16'h0400;
  logic done, pins, go, start, status, handoff;
  load_rsp_s rsp;
  logic [1:0] cfg;
  logic [31:0] vec;
  mod_en_t en;
  emif_wait_s wt;
  load_req_s req;
  load_req_s reqs[$];
  int fail_count = 0, cmp_count = 0;

  boot_strap_config_sequencer #(.TOGGLE_FAST_CYCLES(8),
    .TOGGLE_SLOW_CYCLES(16)) dut_u (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_boot_select_strap(strap), .i_load_done(done), .i_load_rsp(rsp),
    .i_nand_page_bytes(page), .i_nand_wide(wide), .o_pins_to_emif(pins),
    .o_boot_config_word(cfg), .o_fetch_vector(vec), .o_fetch_go(go),
    .o_module_enable(en), .o_emif_wait(wt), .o_load_start(start),
    .o_load_req(req), .o_boot_status_output(status), .o_handoff(handoff));

  load_engine_model m_u (.i_mclk(mclk), .i_rst_n(rst_n), .i_start(start),
    .i_fails(fails), .i_err(err), .i_delay(dly), .i_bytes(bytes),
    .o_done(done), .o_rsp(rsp));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Log every load request as the design issues it
  always @(posedge mclk) begin
    if (start === 1'b1) reqs.push_back(req);
  end

  task automatic check(input string nm, input logic [40:0] exp,
    input logic [40:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reset held 16 cycles; inputs change 1 ns after the edge
  task automatic run(input logic [1:0] s, input logic [7:0] f,
    input logic e, input logic [15:0] b, input logic w,
    input logic [15:0] p, input logic [7:0] d);
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    strap = s;
    fails = f;
    err = e;
    bytes = b;
    wide = w;
    page = p;
    dly = d;
    repeat (16) @(posedge mclk);
    #1;
    reqs.delete();
    rst_n = 1'b1;
  endtask

  // Bounded wait; sel 0 fetch go, 1 handoff, 2 status change
  task automatic wait_for(input int sel, input int lim, output int n);
    logic old;
    old = status;
    n = 0;
    do begin
      @(posedge mclk);
      #2;
      n++;
    end while (n < lim && !((sel == 0 && go === 1'b1) ||
      (sel == 1 && handoff === 1'b1) || (sel == 2 && status !== old)));
    if (n >= lim) check("wait", sel, 41'h1FF);
  endtask

  function automatic mod_en_t exp_en(input logic [1:0] s);
    mod_en_t e;
    e = '0;
    for (int k = `MOD_BUS_LO; k <= `MOD_BUS_HI; k++) e[k] = 1'b1;
    e[`MOD_TIMER2] = 1'b1;
    e[`MOD_SYSTEM] = 1'b1;
    e[`MOD_CPU] = 1'b1;
    e[`MOD_FIRST_GENERAL_TIMER] = 1'b1;
    e[`MOD_EMIF] = (s != 2'h2);
    e[`MOD_DMA_CC] = (s != 2'h2);
    e[`MOD_DMA_TC0] = (s != 2'h2);
    e[`MOD_DMA_TC1] = (s != 2'h2);
    e[`MOD_CARD0] = (s == 2'h2);
    e[`MOD_UART0] = (s == 2'h3);
    return e;
  endfunction

  // Source rows: strap fails err bytes wide page count last-source
  typedef struct packed {
    logic [1:0] s;
    logic [7:0] f;
    logic e;
    logic [15:0] b;
    logic w;
    logic [15:0] p;
    logic [7:0] cnt;
    logic [1:0] last;
  } row_s;
  row_s rows[8] = '{
    '{2'h0, 8'd1, 1'b0, 16'h0400, 1'b0, 16'h0800, 8'd2, 2'h1},
    '{2'h2, 8'd2, 1'b0, 16'h0400, 1'b0, 16'h0800, 8'd3, 2'h2},
    '{2'h0, 8'd25, 1'b1, 16'h0400, 1'b0, 16'h0800, 8'd26, 2'h1},
    '{2'h2, 8'd25, 1'b1, 16'h0400, 1'b0, 16'h0800, 8'd26, 2'h2},
    '{2'h0, 8'd0, 1'b0, 16'h0400, 1'b1, 16'h0800, 8'd1, 2'h1},
    '{2'h0, 8'd0, 1'b0, 16'h0400, 1'b0, 16'h2001, 8'd1, 2'h1},
    '{2'h0, 8'd0, 1'b0, 16'h0400, 1'b0, 16'h2000, 8'd1, 2'h0},
    '{2'h0, 8'd0, 1'b0, 16'h7801, 1'b0, 16'h0800, 8'd2, 2'h1}};

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    int n;
    // Every strap value through a full reset and boot
    for (int s = 0; s < 4; s++) begin
      run(s[1:0], 8'd0, 1'b0, 16'h7800, 1'b0, 16'h2000, 8'd3);
      wait_for(0, 20, n);
      check("vector", (s == 1) ? `EMIF_START_VEC : `ROM_START_VEC, vec);
      check("config", s[1:0], cfg);
      check("pins", 1'b1, pins);
      check("enable", exp_en(s[1:0]), en);
      check("wait", (s == 2) ? 16'h0 : {`WAIT_SETUP, `WAIT_STROBE,
        `WAIT_HOLD}, wt);
      check("status", 1'b0, status);
      @(posedge mclk);
      #1;
      strap = ~s[1:0];
      if (s == 1) begin
        repeat (60) @(posedge mclk);
        check("starts", 0, reqs.size());
        check("config", 2'h1, cfg);
      end else begin
        wait_for(1, 200, n);
        check("status", 1'b1, status);
        check("starts", 1, reqs.size());
        check("src", (s == 0) ? SRC_NAND : (s == 2) ? SRC_CARD : SRC_UART,
          reqs[0].src);
      end
      $display("strap %0d test done", s);
    end
    // Fallbacks, retries, size and page limits
    foreach (rows[i]) begin
      run(rows[i].s, rows[i].f, rows[i].e, rows[i].b, rows[i].w,
        rows[i].p, 8'd2);
      wait_for(1, 2000, n);
      check("starts", rows[i].cnt, reqs.size());
      check("last src", rows[i].last, reqs[$].src);
      $display("source row %0d test done", i);
    end
    // NAND, card, USB, USB again with fast blink timing
    run(2'h0, 8'd3, 1'b0, 16'h0400, 1'b0, 16'h0800, 8'd30);
    repeat (20) @(posedge mclk);
    check("status", 1'b0, status);
    wait (reqs.size() == 2);
    wait_for(2, 40, n);
    wait_for(2, 40, n);
    check("fast period", 8, n);
    wait_for(1, 400, n);
    check("status", 1'b1, status);
    check("seq", {SRC_NAND, SRC_CARD, SRC_USB, SRC_USB}, {reqs[0].src,
      reqs[1].src, reqs[2].src, reqs[3].src});
    check("cs hold", 1'b1, reqs[0].cs_hold);
    check("native", 1'b1, reqs[1].card_native);
    $display("fallback test done");
    // UART retries with slow blink timing
    run(2'h3, 8'd2, 1'b0, 16'h0400, 1'b0, 16'h0800, 8'd60);
    wait (reqs.size() == 2);
    wait_for(2, 60, n);
    wait_for(2, 60, n);
    check("slow period", 16, n);
    wait_for(1, 400, n);
    check("seq", {SRC_UART, SRC_UART, SRC_UART}, {reqs[0].src,
      reqs[1].src, reqs[2].src});
    $display("uart retry test done");
    final_report();
  end
endmodule
`default_nettype wire
